// ==== rtl/jump_inc_pkg.sv ====
// package for the long jump / file-byte increment execution block
// shared by the design and the bench: register map, field layout, phases, carriers
package jump_inc_pkg;

   // apb register byte offsets
   localparam logic [7:0] REG_CTRL   = 8'h00;  // bit0: extended instruction set enable
   localparam logic [7:0] REG_BANK   = 8'h04;  // bank_select_register, 4 bits
   localparam logic [7:0] REG_WORK   = 8'h08;  // working register, 8 bits
   localparam logic [7:0] REG_STATUS = 8'h0C;  // flags, read only
   localparam logic [7:0] REG_PC     = 8'h10;  // program counter, read only
   localparam logic [7:0] REG_INDEX  = 8'h14;  // base of indexed literal offset, 12 bits

   // reset values
   localparam logic        CTRL_RESET  = 1'b0;
   localparam logic [3:0]  BANK_RESET  = 4'h0;
   localparam logic [7:0]  WORK_RESET  = 8'h00;
   localparam logic [11:0] INDEX_RESET = 12'h000;
   localparam logic [20:0] PC_RESET    = 21'h000000;

   // status field positions
   localparam int FLAG_C           = 0;
   localparam int FLAG_DIGIT_CARRY = 1;
   localparam int FLAG_Z           = 2;
   localparam int FLAG_OVERFLOW    = 3;
   localparam int FLAG_N           = 4;

   // instruction encodings
   localparam logic [7:0]  JUMP_OPC    = 8'hEF;   // first word: opcode, k<7:0>
   localparam logic [5:0]  INC_OPC     = 6'h0A;   // 0010_10da_ffff_ffff
   localparam logic [7:0]  LIT_LIMIT   = 8'h5F;   // highest indexed literal offset
   localparam logic [3:0]  ACCESS_HIGH = 4'hF;    // bank of the upper access area
   localparam logic [3:0]  ACCESS_LOW  = 4'h0;    // bank of the lower access area

   // phase counter of the four-phase instruction cycle
   localparam logic [1:0] PH_Q1 = 2'h0;
   localparam logic [1:0] PH_Q2 = 2'h1;
   localparam logic [1:0] PH_Q3 = 2'h2;
   localparam logic [1:0] PH_Q4 = 2'h3;

   typedef enum logic [1:0] {
      OP_NONE     = 2'b00,
      OP_JUMP     = 2'b01,
      OP_JUMP_NOP = 2'b10,
      OP_INC      = 2'b11
   } op_type;

   typedef struct packed {
      logic        n;
      logic        overflow;
      logic        z;
      logic        digit_carry;
      logic        c;
   } flags_type;

   // data memory request carrier
   typedef struct packed {
      logic [11:0] addr;
      logic        rd;
      logic        we;
      logic [7:0]  wdata;
   } dmem_req_type;

   // apb answer carrier
   typedef struct packed {
      logic        ready;
      logic        slverr;
      logic [31:0] rdata;
   } apb_rsp_type;

endpackage

// ==== rtl/jump_and_increment_exec.sv ====
// execution block for the long jump and the file-byte increment of an 8-bit core
// assumes fetch and data memory run on mclk_i; instruction words and read data arrive
// from logic on the same clock, so they are not synchronised
// the block decodes two instructions only; any other word acts as a no-operation
// its registers are reached over apb, one aligned word each
// no interrupt and no clock enable: every register runs on every edge
`timescale 1ns/1ps
`default_nettype none

module jump_and_increment_exec
   import jump_inc_pkg::*;
#(
   parameter int PC_WIDTH = 21
) (
   input  wire logic         mclk_i,
   input  wire logic         resetn_i,
   // instruction words from fetch
   input  wire logic [15:0]  instr_i,
   input  wire logic         instr_valid_i,
   output logic [1:0]        phase_o,
   output logic [20:0]       pc_o,
   output logic              pc_load_o,
   output logic              flush_o,
   // data register file
   output logic [11:0]       dmem_addr_o,
   output logic              dmem_rd_o,
   output logic              dmem_we_o,
   output logic [7:0]        dmem_wdata_o,
   input  wire logic [7:0]   dmem_rdata_i,
   // apb slave
   input  wire logic         psel_i,
   input  wire logic         penable_i,
   input  wire logic         pwrite_i,
   input  wire logic [7:0]   paddr_i,
   input  wire logic [31:0]  pwdata_i,
   output logic [31:0]       prdata_o,
   output logic              pready_o,
   output logic              pslverr_o
);

   // the pc layout is fixed by the 20-bit target plus the byte bit; a narrower pc
   // could not reach the whole 2-Mbyte space and a wider one would have no source
   if (PC_WIDTH != 21) begin : g_bad_pc
      $error("jump_and_increment_exec: PC_WIDTH must be 21");
   end

   // every flip-flop of the block lives in this one record
   typedef struct packed {
      // phase sequencer and the instruction in flight
      logic [1:0]   phase;
      op_type       op;
      logic [15:0]  instr;
      // scratch of the running instruction
      logic [7:0]   klow;          // low target byte, kept from Q2 to Q4
      logic [7:0]   operand;
      logic [7:0]   result;
      flags_type    flags_new;     // held aside so a jump never touches the flags
      // state that software sees over apb
      flags_type    flags;
      logic [7:0]   work;
      logic [3:0]   bank;
      logic         ext_en;
      logic [11:0]  index_base;
      logic [20:0]  pc;
      // one-clock pulses towards fetch
      logic         pc_load;
      logic         flush;
      // carriers towards data memory and the bus
      dmem_req_type dmem;
      apb_rsp_type  apb;
   } state_type;

   // s is the registered state, next_s its value at the coming edge
   state_type s;
   state_type next_s;

   // true when the word is the first word of a long jump
   // the second word is taken in Q4 without a look at its opcode bits
   function automatic logic is_jump(input logic [15:0] w);
      return w[15:8] == JUMP_OPC;
   endfunction

   // true when the word is an increment of a file byte
   // d is bit 9 and a is bit 8 of the word
   function automatic logic is_inc(input logic [15:0] w);
      return w[15:10] == INC_OPC;
   endfunction

   // data address of a byte-oriented operand
   // the indexed base plus offset wraps inside 12 bits; software keeps the base
   // at least 96 bytes below the top of the data space
   function automatic logic [11:0] file_addr(input logic [15:0] w, input logic [3:0] bank,
                                             input logic ext_en, input logic [11:0] base);
      logic [7:0] f;
      f = w[7:0];
      if (w[8]) begin
         file_addr = {bank, f};
      end else if (ext_en && f <= LIT_LIMIT) begin
         file_addr = base + {4'h0, f};
      end else if (f <= LIT_LIMIT) begin
         file_addr = {ACCESS_LOW, f};
      end else begin
         file_addr = {ACCESS_HIGH, f};
      end
   endfunction

   // apb read mux; unmapped offsets answer zero
   // upper bits of every register read as zero
   function automatic logic [31:0] read_reg(input state_type r, input logic [7:0] a);
      case (a)
         REG_CTRL:   read_reg = {31'h00000000, r.ext_en};
         REG_BANK:   read_reg = {28'h0000000, r.bank};
         REG_WORK:   read_reg = {24'h000000, r.work};
         REG_STATUS: read_reg = {27'h0000000, r.flags};
         REG_PC:     read_reg = {11'h000, r.pc};
         REG_INDEX:  read_reg = {20'h00000, r.index_base};
         default:    read_reg = 32'h00000000;
      endcase
   endfunction

   // true for offsets that complete without an error response
   function automatic logic mapped(input logic [7:0] a);
      return a == REG_CTRL || a == REG_BANK || a == REG_WORK ||
             a == REG_STATUS || a == REG_PC || a == REG_INDEX;
   endfunction

   // next-state logic for the phase sequencer, execution and register bus
   // one clock per phase, each instruction cycle being four clocks:
   //   Q1  decode; an increment drives its address and read strobe for Q2
   //   Q2  operand byte or low target byte taken at the closing edge
   //   Q3  sum and flags formed; a write-back raises the write strobe for Q4
   //   Q4  destination, flags and pc written at the closing edge
   //   Q1  after a jump, pc_load_o and flush_o pulse and the word on instr_i is dropped
   // the phase runs free from reset, so fetch must line its words up with phase_o
   always_comb begin
      // locals of the compute phase and the bus handshake, cleared first so no latch is inferred
      logic [8:0] sum;
      logic [4:0] low_sum;
      logic       apb_done;
      sum      = 9'h000;
      low_sum  = 5'h00;
      apb_done = 1'b0;
      next_s   = s;

      // defaults: pulses last one clock unless a phase below raises them again
      next_s.phase   = s.phase + 2'h1;   // Q1..Q4 roll over every four clocks
      next_s.pc_load = 1'b0;
      next_s.flush   = 1'b0;

      case (s.phase)
         PH_Q1: begin
            // decode; the cycle after a long jump is forced to a no-operation
            // the word is copied every Q1 so Q2 and Q4 can read its fields
            next_s.instr = instr_i;
            if (s.op == OP_JUMP) begin
               next_s.op = OP_JUMP_NOP;
            end else if (instr_valid_i && is_jump(instr_i)) begin
               next_s.op = OP_JUMP;
            end else if (instr_valid_i && is_inc(instr_i)) begin
               next_s.op = OP_INC;
               // address and strobe go out together for the Q2 clock
               next_s.dmem.addr = file_addr(instr_i, s.bank, s.ext_en, s.index_base);
               next_s.dmem.rd   = 1'b1;
            end else begin
               next_s.op = OP_NONE;
            end
         end
         PH_Q2: begin
            // read: operand byte or low target byte
            // the read strobe stands for this one clock only
            next_s.dmem.rd = 1'b0;
            if (s.op == OP_JUMP) begin
               next_s.klow = s.instr[7:0];
            end
            if (s.op == OP_INC) begin
               next_s.operand = dmem_rdata_i;
            end
         end
         PH_Q3: begin
            // compute; flags held aside until the write phase ends
            if (s.op == OP_INC) begin
               sum     = {1'b0, s.operand} + 9'h001;
               low_sum = {1'b0, s.operand[3:0]} + 5'h01;
               next_s.result       = sum[7:0];
               next_s.flags_new.c           = sum[8];
               next_s.flags_new.digit_carry = low_sum[4];         // carry out of bit 3
               next_s.flags_new.z           = sum[7:0] == 8'h00;
               next_s.flags_new.n           = sum[7];
               next_s.flags_new.overflow    = s.operand == 8'h7F; // positive to negative
               // write-back: the strobe stands for exactly the Q4 clock
               if (s.instr[9]) begin
                  next_s.dmem.we    = 1'b1;
                  next_s.dmem.wdata = sum[7:0];
               end
            end
         end
         default: begin
            // Q4: write destination; second jump word is on instr_i now
            // the write strobe ends with this clock
            next_s.dmem.we = 1'b0;
            if (s.op == OP_JUMP) begin
               // second word: bits 11..0 carry the upper twelve target bits
               next_s.pc      = {instr_i[11:0], s.klow, 1'b0};
               next_s.pc_load = 1'b1;
               next_s.flush   = 1'b1;
            end
            if (s.op == OP_INC) begin
               // flags commit together with the destination
               next_s.flags = s.flags_new;
               if (!s.instr[9]) begin
                  next_s.work = s.result;
               end
            end
            // the forced no-operation cycle ends here; the next Q1 decodes again
            if (s.op == OP_JUMP_NOP) begin
               next_s.op = OP_NONE;
            end
         end
      endcase

      // apb: answer one clock into the access phase; writes land on the completing edge
      // the wait state lets the read mux see registers that settled at the previous edge,
      // at the cost of one clock per transfer
      // apb_done marks the edge at which the master samples pready high
      apb_done         = psel_i && penable_i && s.apb.ready;
      next_s.apb.ready = psel_i && penable_i && !s.apb.ready;

      // capture the answer at the edge that closes the wait state and raises pready
      if (psel_i && penable_i && !s.apb.ready) begin
         next_s.apb.slverr = !mapped(paddr_i);
         next_s.apb.rdata  = pwrite_i ? 32'h00000000 : read_reg(s, paddr_i);
      end else begin
         next_s.apb.slverr = 1'b0;
      end

      // register writes; read-only and unmapped offsets are ignored here
      if (apb_done && pwrite_i) begin
         case (paddr_i)
            REG_CTRL:  next_s.ext_en     = pwdata_i[0];
            REG_BANK:  next_s.bank       = pwdata_i[3:0];
            REG_INDEX: next_s.index_base = pwdata_i[11:0];
            REG_WORK: begin
               // the increment result wins a same-edge collision on the working register
               if (!(s.phase == PH_Q4 && s.op == OP_INC && !s.instr[9])) begin
                  next_s.work = pwdata_i[7:0];
               end
            end
            default: ;
         endcase
      end
   end

   // single state register; asynchronous reset loads constants only
   // phase 0 at reset makes the clock during release the first Q1
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         // the whole record to zero, then the reset values of the package
         s            <= '0;
         s.op         <= OP_NONE;
         s.work       <= WORK_RESET;
         s.bank       <= BANK_RESET;
         s.ext_en     <= CTRL_RESET;
         s.index_base <= INDEX_RESET;
         s.pc         <= PC_RESET;
      end else begin
         s <= next_s;
      end
   end

   // outputs taken straight from the state register
   // fetch side
   assign phase_o      = s.phase;
   assign pc_o         = s.pc;
   assign pc_load_o    = s.pc_load;
   assign flush_o      = s.flush;

   // data memory side
   assign dmem_addr_o  = s.dmem.addr;
   assign dmem_rd_o    = s.dmem.rd;
   assign dmem_we_o    = s.dmem.we;
   assign dmem_wdata_o = s.dmem.wdata;

   // bus side
   assign prdata_o     = s.apb.rdata;
   assign pready_o     = s.apb.ready;
   assign pslverr_o    = s.apb.slverr;

endmodule

`default_nettype wire

// ==== sim/jump_inc_chk.sv ====
// checker for the long jump and file-byte increment block, bound to its ports
// assumes one clock domain and an active-low asynchronous reset
`timescale 1ns/1ps
`default_nettype none
module jump_inc_chk
   import jump_inc_pkg::*;
(
   input wire logic        mclk_i,
   input wire logic        resetn_i,
   input wire logic [15:0] instr_i,
   input wire logic        instr_valid_i,
   input wire logic [1:0]  phase_o,
   input wire logic [20:0] pc_o,
   input wire logic        pc_load_o,
   input wire logic        flush_o,
   input wire logic        dmem_rd_o,
   input wire logic        dmem_we_o,
   input wire logic [7:0]  dmem_wdata_o,
   input wire logic [7:0]  dmem_rdata_i,
   input wire logic        psel_i,
   input wire logic        penable_i,
   input wire logic        pready_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!resetn_i);
   // a word is taken only in a Q1 outside the forced nop cycle
   sequence s_take;
      phase_o == PH_Q1 && instr_valid_i && !pc_load_o;
   endsequence
   sequence s_jump;
      s_take ##0 instr_i[15:8] == JUMP_OPC;
   endsequence
   sequence s_inc;
      s_take ##0 instr_i[15:10] == INC_OPC;
   endsequence
   AST_PHASE_STEP:
      assert property ($past(resetn_i) |-> phase_o == $past(phase_o) + 2'h1) else $error("phase skipped");
   AST_RD_Q2:
      assert property (dmem_rd_o |-> phase_o == PH_Q2 && !dmem_we_o) else $error("read outside Q2");
   AST_WE_Q4:
      assert property (dmem_we_o |-> phase_o == PH_Q4 && $past(dmem_rd_o, 2)) else $error("write outside Q4");
   AST_WDATA:
      assert property (dmem_we_o |-> dmem_wdata_o == $past(dmem_rdata_i, 2) + 8'h01) else $error("bad sum");
   AST_INC_FLOW:
      assert property (s_inc |=> dmem_rd_o ##2 dmem_we_o == $past(instr_i[9], 3)) else $error("bad inc flow");
   AST_JUMP_PC:
      assert property (s_jump ##3 1'b1 |=> pc_load_o && pc_o == {$past(instr_i[11:0]), $past(instr_i[7:0], 4), 1'b0})
         else $error("bad jump target");
   AST_PC_HOLD:
      assert property (!pc_load_o |-> $stable(pc_o)) else $error("pc moved without jump");
   AST_NOP_CYCLE:
      assert property (pc_load_o |-> phase_o == PH_Q1 ##1 (!pc_load_o && !dmem_rd_o)[*3] ##1 !pc_load_o[*4])
         else $error("nop cycle broken");
   AST_FLUSH_PAIR:
      assert property (flush_o == pc_load_o) else $error("flush apart from load");
   AST_APB_WAIT:
      assert property (psel_i && penable_i && !pready_o |=> pready_o ##1 !pready_o) else $error("apb wait wrong");
endmodule
bind jump_and_increment_exec jump_inc_chk u_chk (.mclk_i, .resetn_i, .instr_i, .instr_valid_i, .phase_o, .pc_o,
   .pc_load_o, .flush_o, .dmem_rd_o, .dmem_we_o, .dmem_wdata_o, .dmem_rdata_i, .psel_i, .penable_i, .pready_o);
`default_nettype wire

// ==== sim/dmem_model.sv ====
// data register file model at the far side of the block
// assumes reads answer within the Q2 clock and writes land on the rising edge
`timescale 1ns/1ps
`default_nettype none
module dmem_model (
   input  wire logic        clk_i,
   input  wire logic [11:0] addr_i,
   input  wire logic        rd_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  wdata_i,
   output logic [7:0]       rdata_o
);
   logic [7:0] mem [0:4095];
   logic [7:0] last = 8'hA5;
   // plain always so the bench may preload bytes
   always @(posedge clk_i) begin
      if (we_i) mem[addr_i] <= wdata_i;
      if (rd_i) last <= mem[addr_i];
   end
   // idle bus shows the inverse of the last byte, so stale data never passes
   assign rdata_o = rd_i ? mem[addr_i] : ~last;
endmodule
`default_nettype wire

// ==== sim/jump_and_increment_exec_tb.sv ====
// self-checking bench for the long jump and file-byte increment block
// assumes dmem_model as data memory; instructions and apb are driven here
`timescale 1ns/1ps
`default_nettype none
module jump_and_increment_exec_tb import jump_inc_pkg::*;;
   logic        mclk_i = 1'b0, resetn_i = 1'b0, instr_valid_i = 1'b0;
   logic        psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
   logic [15:0] instr_i = 16'h0000;
   logic [7:0]  paddr_i = 8'h00, dmem_wdata_o, dmem_rdata_i;
   logic [31:0] pwdata_i = 32'h0, prdata_o;
   logic [1:0]  phase_o;
   logic [20:0] pc_o;
   logic [11:0] dmem_addr_o;
   logic        pc_load_o, flush_o, dmem_rd_o, dmem_we_o, pready_o, pslverr_o;
   int          num_errors = 0, total_checks = 0, cycles = 0;
   jump_and_increment_exec dut (.mclk_i, .resetn_i, .instr_i, .instr_valid_i, .phase_o, .pc_o, .pc_load_o, .flush_o,
      .dmem_addr_o, .dmem_rd_o, .dmem_we_o, .dmem_wdata_o, .dmem_rdata_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
      .pwdata_i, .prdata_o, .pready_o, .pslverr_o);
   dmem_model u_dmem (.clk_i(mclk_i), .addr_i(dmem_addr_o), .rd_i(dmem_rd_o), .we_i(dmem_we_o),
      .wdata_i(dmem_wdata_o), .rdata_o(dmem_rdata_i));
   // clock, and a hang guard far above the few hundred cycles needed
   always #25 mclk_i = ~mclk_i;
   always @(posedge mclk_i) begin
      cycles++;
      if (cycles == 4000) begin
         num_errors++;
         final_report();
      end
   end
   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   // request held until pready is sampled high, then released
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
      @(posedge mclk_i);
      {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {2'b10, w, a, d};
      @(posedge mclk_i);
      penable_i <= 1'b1;
      do @(posedge mclk_i); while (pready_o !== 1'b1);
      r = prdata_o;
      e = pslverr_o;
      {psel_i, penable_i} <= 2'b00;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] x, input string n);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0, r, e);
      chk(n, x, r);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask
   task automatic wait_q4();
      do @(posedge mclk_i); while (phase_o !== PH_Q4);
   endtask
   // word placed at the edge that opens Q1
   task automatic issue(input logic [15:0] w);
      wait_q4();
      {instr_i, instr_valid_i} <= {w, 1'b1};
      @(posedge mclk_i);
      instr_valid_i <= 1'b0;
   endtask
   task automatic jump(input logic [19:0] k);
      u_dmem.mem[12'h330] = 8'h55;
      issue({JUMP_OPC, k[7:0]});
      do @(posedge mclk_i); while (phase_o !== PH_Q3);
      instr_i <= {4'hF, k[19:8]};
      @(posedge mclk_i);
      {instr_i, instr_valid_i} <= {INC_OPC, 2'b11, 8'h30, 1'b1}; // would write bank 3 if taken
      #1;
      chk("pc", {11'h0, k, 1'b0}, 32'(pc_o));
      chk("load_flush", 32'h3, {30'h0, pc_load_o, flush_o});
      @(posedge mclk_i);
      instr_valid_i <= 1'b0;
      wait_q4();
      #1;
      chk("nop_byte", 32'h55, 32'(u_dmem.mem[12'h330]));
      // negative flag left by the last increment of the literal test
      rd(REG_STATUS, 32'h10, "flags_kept");
   endtask
   task automatic inc(input logic d, input logic a, input logic [7:0] f, input logic [7:0] v, input logic [11:0] ad,
                      input logic [4:0] fl);
      logic [7:0] s;
      s = v + 8'h01;
      u_dmem.mem[ad] = v;
      issue({INC_OPC, d, a, f});
      wait_q4();
      #1;
      chk("addr", 32'(ad), 32'(dmem_addr_o));
      chk("byte", 32'(d ? s : v), 32'(u_dmem.mem[ad]));
      if (!d) rd(REG_WORK, 32'(s), "work");
      rd(REG_STATUS, 32'(fl), "flags");
   endtask
   task automatic t_regs();
      logic [31:0] r;
      logic        e;
      rd(REG_CTRL, 32'(CTRL_RESET), "ctrl");
      rd(REG_BANK, 32'(BANK_RESET), "bank");
      rd(REG_WORK, 32'(WORK_RESET), "work");
      rd(REG_INDEX, 32'(INDEX_RESET), "index");
      rd(REG_PC, 32'(PC_RESET), "pc");
      wr(REG_STATUS, 32'h1F);
      rd(REG_STATUS, 32'h0, "status_ro");
      wr(REG_BANK, 32'hFFFFFFF3);
      rd(REG_BANK, 32'h3, "bank_upper");
      apb(1'b0, 8'h18, 32'h0, r, e);
      chk("unmapped", 32'h1, {31'h0, e});
      $display("test regs done");
   endtask
   task automatic t_jump();
      jump(20'hABCDE);
      jump(20'hFFFFF);
      $display("test jump done");
   endtask
   // wrap to zero into the working register, then overflow into the byte
   task automatic t_inc_dest();
      inc(1'b0, 1'b1, 8'h12, 8'hFF, 12'h312, 5'h07);
      inc(1'b1, 1'b0, 8'h80, 8'h7F, 12'hF80, 5'h1A);
      inc(1'b1, 1'b0, 8'h20, 8'h41, 12'h020, 5'h00);
      $display("test inc dest done");
   endtask
   // indexed offset at and just past its upper limit
   task automatic t_inc_lit();
      wr(REG_CTRL, 32'h1);
      wr(REG_INDEX, 32'h200);
      inc(1'b1, 1'b0, 8'h5F, 8'h0F, 12'h25F, 5'h02);
      inc(1'b1, 1'b0, 8'h60, 8'h0E, 12'hF60, 5'h00);
      inc(1'b1, 1'b1, 8'h40, 8'hFE, 12'h340, 5'h10);
      $display("test inc literal done");
   endtask
   initial begin
      repeat (20) @(posedge mclk_i);
      resetn_i <= 1'b1;
      t_regs();
      t_inc_dest();
      t_inc_lit();
      t_jump();
      final_report();
   end
endmodule
`default_nettype wire
